// file: pts_cfg.svh
// Bit positions, reset values and source codes of the timer set
`ifndef PTS_CFG_SVH
`define PTS_CFG_SVH

// Data and register widths
`define PTS_DATA_W        8
`define PTS_CTL_W         4
`define PTS_PSC_CTL_W     2

// Prescaler control fields
`define PTS_PSC_RUN_BIT   0
`define PTS_PSC_SRC_BIT   1

// First counter control fields
`define PTS_C1_SRC_LSB    0
`define PTS_C1_SRC_MSB    1
`define PTS_C1_RUN_BIT    2
`define PTS_C1_ASTOP_BIT  3

// Second counter control fields
`define PTS_C2_SRC_LSB    0
`define PTS_C2_SRC_MSB    1
`define PTS_C2_RUN_BIT    2
`define PTS_C2_OSEL_BIT   3

// Third counter control fields
`define PTS_C3_SRC_BIT    0
`define PTS_C3_RUN_BIT    1
`define PTS_C3_EXT_BIT    2
`define PTS_C3_PWM_BIT    3

// Pin and sync control fields
`define PTS_PC_SHARED_BIT 0
`define PTS_PC_GATE_BIT   1
`define PTS_PC_EDGE_BIT   2
`define PTS_PC_SYNC_BIT   3

// Reset values
`define PTS_CTL_RST       4'h0
`define PTS_PSC_CTL_RST   2'h0

// Count source codes of the first and second counters
`define PTS_SRC_PWM       2'h0
`define PTS_SRC_PSC       2'h1
`define PTS_SRC_SYS       2'h2
`define PTS_SRC_OTHER     2'h3

// Instruction clock divided by four: last phase of the divider
`define PTS_INST_DIV_LAST 2'h3

`endif

// file: pts_pkg.sv
// Types shared by the timer set
`default_nettype none
package pts_pkg;

   // Timer transfer instructions issued by the core
   typedef enum logic [4:0] {
      I_NOP, I_PSC_LOAD, I_PSC_READ, I_FIRST_LOAD_RELOAD, I_FIRST_LOAD,
      I_FIRST_READ, I_SECOND_LOAD, I_SECOND_READ, I_THIRD_LOAD,
      I_HIGH_RELOAD_LOAD, I_LOW_RELOAD_COPY, I_THIRD_READ, I_PSC_CTL_WR,
      I_CTL1_WR, I_CTL1_RD, I_CTL2_WR, I_CTL2_RD, I_CTL3_WR, I_CTL3_RD,
      I_PIN_CTL_WR, I_PIN_CTL_RD
   } pts_instr_t;

   // PWM phase of the third counter
   typedef enum logic [2:0] {
      PWM_LOW  = 3'b001,
      PWM_HIGH = 3'b010,
      PWM_EXT  = 3'b100
   } pts_pwm_state_t;

endpackage : pts_pkg
`default_nettype wire

// file: pts_reload_counter.sv
// Auto-reload down counter with load port and underflow pulse
`default_nettype none
module pts_reload_counter #(
   parameter int unsigned W = 8
) (
   // Clock, reset, enable
   input  wire logic         clk_sys_i,
   input  wire logic         sys_rst_i,
   input  wire logic         ce_i,
   // Count control
   input  wire logic         run_i,
   input  wire logic         tick_i,
   input  wire logic         load_i,
   input  wire logic [W-1:0] load_val_i,
   input  wire logic [W-1:0] reload_i,
   // Count state
   output logic [W-1:0]      count_o,
   output logic              uf_o
);
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;

   // Underflow is the count pulse that finds zero
   assign uf_o    = run_i && tick_i && (cnt_q == '0);
   assign cnt_d   = load_i ? load_val_i :
                    uf_o ? reload_i :
                    (run_i && tick_i) ? cnt_q - 1'b1 : cnt_q;
   assign count_o = cnt_q;

   // Count register
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         cnt_q <= '0;
      end else if (ce_i) begin
         cnt_q <= cnt_d;
      end
   end
endmodule : pts_reload_counter
`default_nettype wire

// file: pts_pin_edge.sv
// Count pin synchroniser and selectable edge detector
`default_nettype none
module pts_pin_edge (
   // Clock, reset, enable
   input  wire logic clk_sys_i,
   input  wire logic sys_rst_i,
   input  wire logic ce_i,
   // Pin and edge choice
   input  wire logic pin_i,
   input  wire logic rise_sel_i,
   // One-cycle count enable
   output logic      edge_o
);
   logic meta_q;
   logic sync_q;
   logic prev_q;

   // Two-stage sync, then a history flop; reset to pin level, no false edge
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         meta_q <= pin_i;
         sync_q <= pin_i;
         prev_q <= pin_i;
      end else if (ce_i) begin
         meta_q <= pin_i;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // Rising when selected, else falling
   assign edge_o = rise_sel_i ? (sync_q && !prev_q) : (!sync_q && prev_q);
endmodule : pts_pin_edge
`default_nettype wire

// file: pts_timer_top.sv
// Prescaled timer set: prescaler, three reload counters, PWM and pins
`default_nettype none
`include "pts_cfg.svh"
module pts_timer_top
   import pts_pkg::*;
#(
   parameter int unsigned CNT_W = `PTS_DATA_W
) (
   // Clock, reset, enable
   input  wire logic             clk_sys_i,
   input  wire logic             sys_rst_i,
   input  wire logic             clk_en_i,
   // Instruction port from the core
   input  wire logic             instr_valid_i,
   input  wire pts_instr_t       instr_i,
   input  wire logic [CNT_W-1:0] acc_i,
   output logic [CNT_W-1:0]      rd_data_o,
   output logic                  rd_valid_o,
   // Count sources and trigger
   input  wire logic             instr_tick_i,
   input  wire logic             crystal_tick_i,
   input  wire logic             ext_trig_valid_i,
   input  wire logic             pin_ctl_en_i,
   // Underflow flags
   input  wire logic [2:0]       flag_clr_i,
   output logic                  first_underflow_flag_o,
   output logic                  second_underflow_flag_o,
   output logic                  third_underflow_flag_o,
   // Shared count pin and port line
   input  wire logic             count_io_pin_i,
   output logic                  count_io_pin_o,
   output logic                  count_io_pin_oe_o,
   input  wire logic             port_line_latch_i,
   input  wire logic             port_line_dir_i,
   output logic                  port_line_o,
   output logic                  port_line_oe_o,
   // PWM pin
   output logic                  pwm_out_pin_o
);
   logic [`PTS_PSC_CTL_W-1:0] psc_ctl_q;
   logic [`PTS_CTL_W-1:0]     ctl1_q, ctl2_q, ctl3_q, pin_ctl_q;
   logic [CNT_W-1:0]          psc_rl_q, first_rl_q, second_rl_q, low_rl_q, high_rl_q;
   logic [CNT_W-1:0]          psc_cnt, t1_cnt, t2_cnt, t3_cnt;
   logic [CNT_W-1:0]          psc_ld_val, t3_ld_val, t3_reload, rd_d;
   logic [1:0]                inst_div_q;
   logic [2:0]                flags_q;
   pts_pwm_state_t            state_q, state_d;
   logic prescaler_output, t1_uf, t2_uf, t3_uf, pin_edge, psc_run, psc_tick, psc_load;
   logic inst4_tick, t1_raw, t1_tick, t2_tick, t3_tick, half_tick, t1_load;
   logic t3_load, t3_run, pwm_on, pwm_level, pwm_rise, sync_active, div_uf;
   logic rd_hit, hold_set, half_q, sync_q, hold_q, gate_q, pwm_prev_q;
   logic cnt_out_q, cnt_oe_q, port_q, port_oe_q, pwm_pin_q, rd_valid_q;
   logic [CNT_W-1:0] rd_data_q;

   // Instruction decode
   function automatic logic op_hit(input pts_instr_t code);
      return instr_valid_i && clk_en_i && (instr_i == code);
   endfunction : op_hit

   // Count source selection shared by counters one and two
   function automatic logic src_pick(input logic [1:0] sel, input logic other);
      if (sel == `PTS_SRC_PWM) begin
         return pwm_rise;
      end else if (sel == `PTS_SRC_PSC) begin
         return prescaler_output;
      end else if (sel == `PTS_SRC_SYS) begin
         return 1'b1;
      end else begin
         return other;
      end
   endfunction : src_pick

   // Control registers written from the accumulator
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         psc_ctl_q <= `PTS_PSC_CTL_RST;
         ctl1_q    <= `PTS_CTL_RST;
         ctl2_q    <= `PTS_CTL_RST;
         ctl3_q    <= `PTS_CTL_RST;
         pin_ctl_q <= `PTS_CTL_RST;
      end else begin
         if (op_hit(I_PSC_CTL_WR)) psc_ctl_q <= acc_i[`PTS_PSC_CTL_W-1:0];
         if (op_hit(I_CTL1_WR)) ctl1_q <= acc_i[`PTS_CTL_W-1:0];
         if (op_hit(I_CTL2_WR)) ctl2_q <= acc_i[`PTS_CTL_W-1:0];
         if (op_hit(I_CTL3_WR)) ctl3_q <= acc_i[`PTS_CTL_W-1:0];
         if (op_hit(I_PIN_CTL_WR)) pin_ctl_q <= acc_i[`PTS_CTL_W-1:0];
      end
   end

   // Reload registers
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         psc_rl_q    <= '0;
         first_rl_q  <= '0;
         second_rl_q <= '0;
         low_rl_q    <= '0;
         high_rl_q   <= '0;
      end else begin
         if (op_hit(I_PSC_LOAD)) psc_rl_q <= acc_i;
         if (op_hit(I_FIRST_LOAD_RELOAD)) first_rl_q <= acc_i;
         if (op_hit(I_SECOND_LOAD)) second_rl_q <= acc_i;
         if (op_hit(I_THIRD_LOAD)) low_rl_q <= acc_i;
         if (op_hit(I_HIGH_RELOAD_LOAD)) high_rl_q <= acc_i;
      end
   end

   // Prescaler source and initialise-while-stopped
   assign inst4_tick = instr_tick_i && (inst_div_q == `PTS_INST_DIV_LAST);
   assign psc_tick   = psc_ctl_q[`PTS_PSC_SRC_BIT] ? inst4_tick : instr_tick_i;
   assign psc_run    = psc_ctl_q[`PTS_PSC_RUN_BIT];
   assign psc_load   = op_hit(I_PSC_LOAD) || !psc_run;
   assign psc_ld_val = op_hit(I_PSC_LOAD) ? acc_i : psc_rl_q;

   // Quarter-rate instruction clock divider
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i || (clk_en_i && !psc_run)) begin
         inst_div_q <= 2'h0;
      end else if (clk_en_i && instr_tick_i) begin
         inst_div_q <= inst_div_q + 2'h1;
      end
   end

   // Prescaler, output feeds the counters
   pts_reload_counter #(.W(CNT_W)) u_psc (
      .clk_sys_i  (clk_sys_i),
      .sys_rst_i  (sys_rst_i),
      .ce_i       (clk_en_i),
      .run_i      (psc_run),
      .tick_i     (psc_tick),
      .load_i     (psc_load),
      .load_val_i (psc_ld_val),
      .reload_i   (psc_rl_q),
      .count_o    (psc_cnt),
      .uf_o       (prescaler_output)
   );

   // Count pin edge enable
   pts_pin_edge u_pin_edge (
      .clk_sys_i  (clk_sys_i),
      .sys_rst_i  (sys_rst_i),
      .ce_i       (clk_en_i),
      .pin_i      (count_io_pin_i),
      .rise_sel_i (pin_ctl_q[`PTS_PC_EDGE_BIT]),
      .edge_o     (pin_edge)
   );

   // First counter source, gated by start sync
   assign sync_active = pin_ctl_en_i && pin_ctl_q[`PTS_PC_SYNC_BIT];
   assign t1_raw  = src_pick(ctl1_q[`PTS_C1_SRC_MSB:`PTS_C1_SRC_LSB], pin_edge);
   assign t1_tick = t1_raw && (!sync_active || sync_q);
   assign t1_load = op_hit(I_FIRST_LOAD_RELOAD) || op_hit(I_FIRST_LOAD);

   pts_reload_counter #(.W(CNT_W)) u_first (
      .clk_sys_i  (clk_sys_i),
      .sys_rst_i  (sys_rst_i),
      .ce_i       (clk_en_i),
      .run_i      (ctl1_q[`PTS_C1_RUN_BIT]),
      .tick_i     (t1_tick),
      .load_i     (t1_load),
      .load_val_i (acc_i),
      .reload_i   (first_rl_q),
      .count_o    (t1_cnt),
      .uf_o       (t1_uf)
   );

   // Second counter
   assign t2_tick = src_pick(ctl2_q[`PTS_C2_SRC_MSB:`PTS_C2_SRC_LSB], t1_uf);

   pts_reload_counter #(.W(CNT_W)) u_second (
      .clk_sys_i  (clk_sys_i),
      .sys_rst_i  (sys_rst_i),
      .ce_i       (clk_en_i),
      .run_i      (ctl2_q[`PTS_C2_RUN_BIT]),
      .tick_i     (t2_tick),
      .load_i     (op_hit(I_SECOND_LOAD)),
      .load_val_i (acc_i),
      .reload_i   (second_rl_q),
      .count_o    (t2_cnt),
      .uf_o       (t2_uf)
   );

   // Third counter sources, reload choice and run hold
   assign pwm_on    = ctl3_q[`PTS_C3_PWM_BIT];
   assign pwm_level = (state_q != PWM_LOW);
   assign pwm_rise  = pwm_level && !pwm_prev_q;
   assign t3_run    = ctl3_q[`PTS_C3_RUN_BIT] || hold_q;
   assign t3_tick   = (ctl3_q[`PTS_C3_SRC_BIT] ? (prescaler_output && half_q) : crystal_tick_i)
                      && (state_q != PWM_EXT);
   assign half_tick = ctl3_q[`PTS_C3_SRC_BIT] ? (prescaler_output && !half_q) : crystal_tick_i;
   assign t3_reload = (pwm_on && state_q == PWM_LOW) ? high_rl_q : low_rl_q;
   assign t3_load   = op_hit(I_THIRD_LOAD) || op_hit(I_LOW_RELOAD_COPY);
   assign t3_ld_val = op_hit(I_THIRD_LOAD) ? acc_i : low_rl_q;
   assign hold_set  = op_hit(I_CTL3_WR) && !acc_i[`PTS_C3_RUN_BIT]
                      && ctl3_q[`PTS_C3_RUN_BIT] && pwm_on && pwm_level;

   pts_reload_counter #(.W(CNT_W)) u_third (
      .clk_sys_i  (clk_sys_i),
      .sys_rst_i  (sys_rst_i),
      .ce_i       (clk_en_i),
      .run_i      (t3_run),
      .tick_i     (t3_tick),
      .load_i     (t3_load),
      .load_val_i (t3_ld_val),
      .reload_i   (t3_reload),
      .count_o    (t3_cnt),
      .uf_o       (t3_uf)
   );

   // PWM phase sequencing with optional extension: half a count on the prescaler source, one count on the crystal source
   always_comb begin
      state_d = state_q;
      if (!pwm_on || !t3_run) begin
         state_d = PWM_LOW;
      end else begin
         case (state_q)
            PWM_LOW: begin
               if (t3_uf) state_d = PWM_HIGH;
            end
            PWM_HIGH: begin
               if (t3_uf) state_d = ctl3_q[`PTS_C3_EXT_BIT] ? PWM_EXT : PWM_LOW;
            end
            PWM_EXT: begin
               if (half_tick) state_d = PWM_LOW;
            end
            default: begin
               state_d = PWM_LOW;
            end
         endcase
      end
   end

   // Third counter state flops
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         state_q    <= PWM_LOW;
         half_q     <= 1'b0;
         hold_q     <= 1'b0;
         pwm_prev_q <= 1'b0;
      end else if (clk_en_i) begin
         state_q    <= state_d;
         half_q     <= t3_run && (half_q ^ prescaler_output);
         hold_q     <= !t3_uf && (hold_q || hold_set);
         pwm_prev_q <= pwm_level;
      end
   end

   // Start sync and auto-gating state
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         sync_q <= 1'b0;
         gate_q <= 1'b0;
      end else if (clk_en_i) begin
         if (!sync_active) begin
            sync_q <= 1'b0;
         end else if (ext_trig_valid_i) begin
            sync_q <= 1'b1;
         end else if (t1_uf && ctl1_q[`PTS_C1_ASTOP_BIT]) begin
            sync_q <= 1'b0;
         end
         if (!t3_run) begin
            gate_q <= 1'b0;
         end else if (pin_ctl_q[`PTS_PC_GATE_BIT] && t1_uf) begin
            gate_q <= !gate_q;
         end
      end
   end

   // Flags, pins and read data
   assign div_uf = ctl2_q[`PTS_C2_OSEL_BIT] ? t2_uf : t1_uf;
   assign rd_hit = op_hit(I_PSC_READ) || op_hit(I_FIRST_READ) || op_hit(I_SECOND_READ)
                   || op_hit(I_THIRD_READ) || op_hit(I_CTL1_RD) || op_hit(I_CTL2_RD)
                   || op_hit(I_CTL3_RD) || op_hit(I_PIN_CTL_RD);
   assign rd_d   = op_hit(I_PSC_READ)    ? psc_rl_q :
                   op_hit(I_FIRST_READ)  ? t1_cnt :
                   op_hit(I_SECOND_READ) ? t2_cnt :
                   op_hit(I_THIRD_READ)  ? t3_cnt :
                   op_hit(I_CTL1_RD)     ? CNT_W'(ctl1_q) :
                   op_hit(I_CTL2_RD)     ? CNT_W'(ctl2_q) :
                   op_hit(I_CTL3_RD)     ? CNT_W'(ctl3_q) :
                   op_hit(I_PIN_CTL_RD)  ? CNT_W'(pin_ctl_q) : '0;

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         flags_q    <= 3'h0;
         cnt_out_q  <= 1'b0;
         cnt_oe_q   <= 1'b0;
         port_q     <= 1'b0;
         port_oe_q  <= 1'b0;
         pwm_pin_q  <= 1'b0;
         rd_data_q  <= '0;
         rd_valid_q <= 1'b0;
      end else if (clk_en_i) begin
         flags_q    <= {t3_uf, t2_uf, t1_uf} | (flags_q & ~flag_clr_i);
         cnt_out_q  <= cnt_out_q ^ div_uf;
         cnt_oe_q   <= pin_ctl_q[`PTS_PC_SHARED_BIT];
         port_q     <= port_line_latch_i;
         port_oe_q  <= !pin_ctl_q[`PTS_PC_SHARED_BIT] && port_line_dir_i;
         pwm_pin_q  <= pwm_on && pwm_level
                       && (!pin_ctl_q[`PTS_PC_GATE_BIT] || gate_q);
         rd_data_q  <= rd_d;
         rd_valid_q <= rd_hit;
      end
   end

   assign first_underflow_flag_o  = flags_q[0];
   assign second_underflow_flag_o = flags_q[1];
   assign third_underflow_flag_o  = flags_q[2];
   assign count_io_pin_o          = cnt_out_q;
   assign count_io_pin_oe_o       = cnt_oe_q;
   assign port_line_o             = port_q;
   assign port_line_oe_o          = port_oe_q;
   assign pwm_out_pin_o           = pwm_pin_q;
   assign rd_data_o               = rd_data_q;
   assign rd_valid_o              = rd_valid_q;

   // Checks
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);

   property p_psc_read;
      op_hit(I_PSC_READ) |=> rd_valid_o && (rd_data_o == $past(psc_rl_q));
   endproperty
   a_psc_read: assert property (p_psc_read) else $error("prescaler read wrong");

   property p_psc_init;
      clk_en_i && !psc_run |=> psc_cnt == psc_rl_q;
   endproperty
   a_psc_init: assert property (p_psc_init) else $error("stopped prescaler not reset");

   property p_first_uf;
      clk_en_i && t1_uf && !t1_load |=> first_underflow_flag_o && t1_cnt == $past(first_rl_q);
   endproperty
   a_first_uf: assert property (p_first_uf) else $error("first underflow wrong");

   property p_second_uf;
      clk_en_i && t2_uf && !op_hit(I_SECOND_LOAD)
         |=> second_underflow_flag_o && t2_cnt == $past(second_rl_q);
   endproperty
   a_second_uf: assert property (p_second_uf) else $error("second underflow wrong");

   property p_third_uf;
      clk_en_i && t3_uf && !pwm_on && !t3_load
         |=> third_underflow_flag_o && t3_cnt == $past(low_rl_q);
   endproperty
   a_third_uf: assert property (p_third_uf) else $error("third underflow wrong");

   property p_sync_gate;
      clk_en_i && sync_active && !sync_q && !t1_load |=> $stable(t1_cnt);
   endproperty
   a_sync_gate: assert property (p_sync_gate) else $error("count before sync");

   property p_auto_stop;
      clk_en_i && sync_active && ctl1_q[`PTS_C1_ASTOP_BIT] && t1_uf && !ext_trig_valid_i
         |=> !sync_q;
   endproperty
   a_auto_stop: assert property (p_auto_stop) else $error("auto-stop missed");

   property p_div2;
      clk_en_i && div_uf |=> count_io_pin_o != $past(count_io_pin_o);
   endproperty
   a_div2: assert property (p_div2) else $error("count pin did not toggle");

   property p_pwm_off;
      clk_en_i && !pwm_on |=> !pwm_out_pin_o ##1 !pwm_out_pin_o || pwm_on;
   endproperty
   a_pwm_off: assert property (p_pwm_off) else $error("PWM pin active while off");

   property p_gate_cancel;
      clk_en_i && !t3_run |=> !gate_q;
   endproperty
   a_gate_cancel: assert property (p_gate_cancel) else $error("gating not cancelled");

   property p_extend;
      clk_en_i && pwm_on && t3_run && state_q == PWM_HIGH && t3_uf && ctl3_q[`PTS_C3_EXT_BIT]
         |=> state_q == PWM_EXT && pwm_level;
   endproperty
   a_extend: assert property (p_extend) else $error("high interval not extended");

endmodule : pts_timer_top
`default_nettype wire

// file: pts_core_model.sv
// Core model issuing timer transfer instructions
`default_nettype none
module pts_core_model
   import pts_pkg::*;
(
   // Clock and read return
   input  wire logic       clk_sys_i,
   input  wire logic [7:0] rd_data_i,
   // Instruction strobe
   output var logic        instr_valid_o,
   output var pts_instr_t  instr_o,
   output var logic [7:0]  acc_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      instr_valid_o = 1'b0;
      instr_o = I_NOP;
      acc_o = 8'h00;
   end
   // One instruction, read data taken one cycle later
   // Callers stop a unit before loading it or changing its source
   task automatic op(input pts_instr_t i, input logic [7:0] d,
                     output logic [7:0] r);
      @(negedge clk_sys_i);
      instr_valid_o = 1'b1;
      instr_o = i;
      acc_o = d;
      @(negedge clk_sys_i);
      instr_valid_o = 1'b0;
      acc_o = ~d; // Released bus does not keep the old value
      r = rd_data_i;
   endtask : op
endmodule : pts_core_model
`default_nettype wire

// file: test_pts_timer_top.sv
// Self-checking bench for the prescaled timer set
`default_nettype none
`define CHK(nm, ex, gt) \
   cmp_count++; \
   if ((gt) !== (ex)) begin \
      bad_count++; \
      $display("ERROR %s exp %0d got %0d", nm, ex, gt); \
   end
module test_pts_timer_top
   import pts_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, iv, rv, tick = 1'b1, f1, f2, f3;
   logic c_o, c_oe, p_o, p_oe, pwm, lat = 1'b1, dir = 1'b1;
   logic pin_en = 1'b0, trig = 1'b0, pin = 1'b0;
   logic [2:0] clr = 3'h7;
   logic [7:0] acc, rd;
   pts_instr_t ins;
   int bad_count = 0, cmp_count = 0, cycles = 0;
   wire logic [4:0] mon = {c_o, pwm, f3, f2, f1};
   // Clock at 100 MHz
   always #5 clk_sys_i = ~clk_sys_i;
   pts_core_model core (.clk_sys_i(clk_sys_i), .rd_data_i(rd), .instr_valid_o(iv),
      .instr_o(ins), .acc_o(acc));
   pts_timer_top uut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1),
      .instr_valid_i(iv), .instr_i(ins), .acc_i(acc), .rd_data_o(rd), .rd_valid_o(rv),
      .instr_tick_i(tick), .crystal_tick_i(1'b1), .ext_trig_valid_i(trig),
      .pin_ctl_en_i(pin_en), .flag_clr_i(clr), .first_underflow_flag_o(f1),
      .second_underflow_flag_o(f2), .third_underflow_flag_o(f3), .count_io_pin_i(pin),
      .count_io_pin_o(c_o), .count_io_pin_oe_o(c_oe), .port_line_latch_i(lat),
      .port_line_dir_i(dir), .port_line_o(p_o), .port_line_oe_o(p_oe),
      .pwm_out_pin_o(pwm));
   // Verdict and end of run
   task automatic give_verdict();
      $display("checks %0d errors %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : give_verdict
   // Hang guard
   always @(posedge clk_sys_i) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         bad_count++;
         give_verdict();
      end
   end
   // Cycles between two rising edges of a watched signal
   task automatic gap(input int s, output int n);
      logic p;
      int r;
      r = 0;
      n = 0;
      p = mon[s];
      while (r < 2 && n < 900) begin
         @(negedge clk_sys_i);
         n = n + 1;
         if (mon[s] === 1'b1 && p !== 1'b1) begin
            r = r + 1;
            if (r == 1) n = 0;
         end
         p = mon[s];
      end
   endtask : gap
   // Prescaler reload read-back and shared pin direction
   task automatic t_pins();
      logic [7:0] r;
      core.op(I_PSC_LOAD, 8'h5a, r);
      core.op(I_PSC_READ, 8'h00, r);
      `CHK("psc reload", 8'h5a, r)
      `CHK("rd valid", 1'b1, rv)
      core.op(I_PIN_CTL_WR, 8'h01, r);
      @(negedge clk_sys_i);
      `CHK("count pin oe", 1'b1, c_oe)
      `CHK("port oe", 1'b0, p_oe)
      core.op(I_PIN_CTL_WR, 8'h00, r);
      @(negedge clk_sys_i);
      `CHK("port oe back", 1'b1, p_oe)
      `CHK("port out", 1'b1, p_o)
   endtask : t_pins
   // First counter from prescaler, then from system clock
   task automatic t_first();
      logic [7:0] r;
      int n;
      core.op(I_PSC_LOAD, 8'h01, r);
      core.op(I_PSC_CTL_WR, 8'h01, r);
      core.op(I_FIRST_LOAD_RELOAD, 8'h02, r);
      core.op(I_CTL1_WR, 8'h05, r);
      gap(0, n);
      `CHK("t1 psc period", 6, n)
      core.op(I_PSC_CTL_WR, 8'h00, r);
      core.op(I_PSC_CTL_WR, 8'h03, r);
      gap(0, n);
      `CHK("t1 psc quarter period", 24, n)
      core.op(I_CTL1_WR, 8'h00, r);
      core.op(I_CTL1_WR, 8'h06, r);
      gap(0, n);
      `CHK("t1 sys period", 3, n)
      gap(4, n);
      `CHK("count pin div2", 6, n)
   endtask : t_first
   // Second counter cascaded on first underflow
   task automatic t_second();
      logic [7:0] r;
      int n;
      core.op(I_SECOND_LOAD, 8'h01, r);
      core.op(I_CTL2_WR, 8'h07, r);
      gap(1, n);
      `CHK("t2 period", 6, n)
      core.op(I_CTL2_RD, 8'h00, r);
      `CHK("ctl2 read", 8'h07, r)
   endtask : t_second
   // Third counter plain, PWM, PWM with extension
   task automatic t_pwm();
      logic [7:0] r;
      int n;
      core.op(I_THIRD_LOAD, 8'h02, r);
      core.op(I_HIGH_RELOAD_LOAD, 8'h04, r);
      core.op(I_CTL3_WR, 8'h02, r);
      gap(2, n);
      `CHK("t3 period", 3, n)
      core.op(I_CTL3_WR, 8'h0a, r);
      gap(3, n);
      `CHK("pwm period", 8, n)
      core.op(I_CTL3_WR, 8'h0e, r);
      gap(3, n);
      `CHK("pwm ext period", 9, n)
      // Stop inside the high interval: runs on to the next underflow
      while (pwm === 1'b1) @(negedge clk_sys_i);
      while (pwm !== 1'b1) @(negedge clk_sys_i);
      core.op(I_CTL3_WR, 8'h0c, r);
      repeat (6) @(negedge clk_sys_i);
      core.op(I_THIRD_READ, 8'h00, r);
      `CHK("t3 held to underflow", 8'h02, r)
      `CHK("pwm after stop", 1'b0, pwm)
      core.op(I_THIRD_LOAD, 8'h05, r);
      core.op(I_CTL3_WR, 8'h02, r);
      core.op(I_CTL3_WR, 8'h00, r);
      core.op(I_THIRD_READ, 8'h00, r);
      `CHK("t3 count", 8'h03, r)
      core.op(I_LOW_RELOAD_COPY, 8'h00, r);
      core.op(I_THIRD_READ, 8'h00, r);
      `CHK("t3 low copy", 8'h05, r)
   endtask : t_pwm
   // One high then low level on the count pin
   task automatic pin_pulse();
      pin = 1'b1;
      repeat (4) @(negedge clk_sys_i);
      pin = 1'b0;
      repeat (4) @(negedge clk_sys_i);
   endtask : pin_pulse
   // Start sync on the trigger, rising pin edges, auto-stop at underflow
   task automatic t_sync();
      logic [7:0] r;
      pin_en = 1'b1;
      core.op(I_CTL1_WR, 8'h00, r);
      core.op(I_FIRST_LOAD, 8'h01, r);
      core.op(I_PIN_CTL_WR, 8'h0c, r);
      core.op(I_CTL1_WR, 8'h0f, r);
      pin_pulse();
      core.op(I_FIRST_READ, 8'h00, r);
      `CHK("t1 held before trigger", 8'h01, r)
      trig = 1'b1;
      @(negedge clk_sys_i);
      trig = 1'b0;
      pin_pulse();
      core.op(I_FIRST_READ, 8'h00, r);
      `CHK("t1 one rising edge", 8'h00, r)
      pin_pulse();
      pin_pulse();
      core.op(I_FIRST_READ, 8'h00, r);
      `CHK("t1 auto-stopped", 8'h02, r)
   endtask : t_sync
   // Main sequence
   initial begin
      repeat (8) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      sys_rst_i = 1'b0;
      t_pins();
      t_first();
      t_second();
      t_pwm();
      t_sync();
      give_verdict();
   end
endmodule : test_pts_timer_top
`default_nettype wire
